// ---- rtl/ptm_timer.sv ----
// Purpose: 10-bit periodic timer with compare, capture and pwm output
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   counter ticks once per selected clock enable
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module ptm_timer (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        capture_pin,
   input  wire logic        ext_clock_pin,
   input  wire logic        tick_int,
   output logic             timer_pin_a,
   output logic             timer_pin_b,
   output logic             match_a_evt,
   output logic             match_p_evt,
   output logic             capture_evt
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] ctrl0_q;
   logic [7:0] mode_q;
   logic [9:0] cmpa_q;
   logic [9:0] per_q;
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;
   logic       out_q;
   logic       on_prev_q;
   logic [2:0] status_q;

   // bus pipeline
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;

   logic        timer_on;
   logic [1:0]  out_func;
   logic [1:0]  mode_sel;
   logic        on_rise;
   logic        match_a;
   logic        match_p;
   logic        tick;
   logic        clr_cnt;
   logic        cap_rise;
   logic        cap_fall;
   logic        ext_rise;
   logic        ext_fall;
   logic        src_rise;
   logic        src_fall;
   logic        cap_hit;
   logic        pwm_level;
   logic        out_level;
   logic        sp_stop;
   logic        bus_go;
   logic        p_quiet;

   localparam int PTM_ON = ptm_pkg::PTM_CTRL0_ON;
   assign timer_on = ctrl0_q[PTM_ON];
   assign out_func = mode_q[ptm_pkg::PTM_MODE_IOHI:ptm_pkg::PTM_MODE_IOLO];
   assign mode_sel = mode_q[ptm_pkg::PTM_MODE_MHI:ptm_pkg::PTM_MODE_MLO];
   assign on_rise  = timer_on & ~on_prev_q;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // high registers keep only two bits, rest reads zero
   function automatic logic [7:0] hi_bits(input logic [9:0] v);
      hi_bits = {6'h00, v[9:8]};
   endfunction : hi_bits

   function automatic logic is_mode(input logic [1:0] m,
                                    input ptm_pkg::ptm_mode_t e);
      is_mode = (m == e);
   endfunction : is_mode

   // ------------------------------------------------------------
   // pin edge detectors
   // ------------------------------------------------------------
   ptm_edge u_cap_edge (
      .clk    (clk),
      .resetn (resetn),
      .din    (capture_pin),
      .rise   (cap_rise),
      .fall   (cap_fall)
   );

   ptm_edge u_ext_edge (
      .clk    (clk),
      .resetn (resetn),
      .din    (ext_clock_pin),
      .rise   (ext_rise),
      .fall   (ext_fall)
   );

   // counter clock: internal tick or external pin edge, held on pause
   always_comb begin
      if (ctrl0_q[ptm_pkg::PTM_CTRL0_CKHI:ptm_pkg::PTM_CTRL0_CKLO]
          == ptm_pkg::PTM_CK_EXT_R) begin
         tick = ext_rise;
      end else if (ctrl0_q[ptm_pkg::PTM_CTRL0_CKHI:ptm_pkg::PTM_CTRL0_CKLO]
                   == ptm_pkg::PTM_CK_EXT_F) begin
         tick = ext_fall;
      end else begin
         tick = tick_int;
      end
      tick = tick & timer_on & ~ctrl0_q[ptm_pkg::PTM_CTRL0_PAU];
   end

   assign match_a = (cnt_q == cmpa_q);
   assign match_p = (cnt_q == per_q);
   // clearing on match A drops the P event
   assign p_quiet = mode_q[ptm_pkg::PTM_MODE_CCLR] &
                    (is_mode(mode_sel, ptm_pkg::PTM_M_CMP) ||
                     is_mode(mode_sel, ptm_pkg::PTM_M_TMR));

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // clear source depends on mode; clear applies on a counting tick
   always_comb begin
      clr_cnt = 1'b0;
      if (is_mode(mode_sel, ptm_pkg::PTM_M_CMP) ||
          is_mode(mode_sel, ptm_pkg::PTM_M_TMR)) begin
         if (mode_q[ptm_pkg::PTM_MODE_CCLR]) begin
            clr_cnt = match_a;
         end else if (per_q == ptm_pkg::PTM_CNT_ZERO) begin
            clr_cnt = (cnt_q == ptm_pkg::PTM_CNT_MAX);
         end else begin
            clr_cnt = match_p;
         end
      end else if (is_mode(mode_sel, ptm_pkg::PTM_M_PWM)) begin
         clr_cnt = (out_func != ptm_pkg::PTM_IO_11) && match_p &&
                   (per_q != ptm_pkg::PTM_CNT_ZERO);
      end else begin
         clr_cnt = match_p && (per_q != ptm_pkg::PTM_CNT_ZERO);
      end
   end

   always_comb begin
      cnt_d = cnt_q;
      if (tick) begin
         cnt_d = clr_cnt ? ptm_pkg::PTM_CNT_ZERO
                         : cnt_q + ptm_pkg::PTM_CNT_ONE;
      end
      if (on_rise) begin
         cnt_d = ptm_pkg::PTM_CNT_ZERO;
      end
   end

   // residual count kept when switched off
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= ptm_pkg::PTM_CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         on_prev_q <= 1'b0;
      end else begin
         on_prev_q <= timer_on;
      end
   end

   // ------------------------------------------------------------
   // capture
   // ------------------------------------------------------------
   // capture source select
   assign src_rise = mode_q[ptm_pkg::PTM_MODE_CAPTS] ? ext_rise : cap_rise;
   assign src_fall = mode_q[ptm_pkg::PTM_MODE_CAPTS] ? ext_fall : cap_fall;

   always_comb begin
      case (out_func)
         ptm_pkg::PTM_IO_00: cap_hit = src_rise;
         ptm_pkg::PTM_IO_01: cap_hit = src_fall;
         ptm_pkg::PTM_IO_10: cap_hit = src_rise | src_fall;
         default:            cap_hit = 1'b0;
      endcase
      cap_hit = cap_hit & timer_on & is_mode(mode_sel, ptm_pkg::PTM_M_CAP);
   end

   // single pulse ends on compare A match
   assign sp_stop = is_mode(mode_sel, ptm_pkg::PTM_M_PWM) &&
                    (out_func == ptm_pkg::PTM_IO_11) && timer_on &&
                    tick && match_a;

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   // compare-mode pin state, before inversion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_q <= 1'b0;
      end else if (on_rise) begin
         out_q <= mode_q[ptm_pkg::PTM_MODE_OC];
      end else if (is_mode(mode_sel, ptm_pkg::PTM_M_CMP) && tick &&
                   match_a) begin
         // forcing equal level is no change
         case (out_func)
            ptm_pkg::PTM_IO_01: out_q <= 1'b0;
            ptm_pkg::PTM_IO_10: out_q <= 1'b1;
            ptm_pkg::PTM_IO_11: out_q <= ~out_q;
            default:            out_q <= out_q;
         endcase
      end
   end

   // pwm and pulse decode, active level from control bit
   always_comb begin
      case (out_func)
         ptm_pkg::PTM_IO_00: pwm_level = 1'b0;
         ptm_pkg::PTM_IO_01: pwm_level = 1'b1;
         ptm_pkg::PTM_IO_10: pwm_level = timer_on && (cnt_q < cmpa_q);
         default:            pwm_level = timer_on;
      endcase
      pwm_level = mode_q[ptm_pkg::PTM_MODE_OC] ? pwm_level : ~pwm_level;
   end

   always_comb begin
      if (is_mode(mode_sel, ptm_pkg::PTM_M_PWM)) begin
         out_level = pwm_level ^ mode_q[ptm_pkg::PTM_MODE_POL];
      end else if (is_mode(mode_sel, ptm_pkg::PTM_M_CMP)) begin
         out_level = out_q ^ mode_q[ptm_pkg::PTM_MODE_POL];
      end else begin
         out_level = 1'b0;
      end
   end

   // both pins share one registered level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer_pin_a <= 1'b0;
         timer_pin_b <= 1'b0;
      end else begin
         timer_pin_a <= out_level;
         timer_pin_b <= out_level;
      end
   end

   // one-cycle event pulses for the interrupt unit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         match_a_evt <= 1'b0;
         match_p_evt <= 1'b0;
         capture_evt <= 1'b0;
      end else begin
         match_a_evt <= tick & match_a;
         match_p_evt <= tick & match_p & ~p_quiet;
         capture_evt <= cap_hit;
      end
   end

   // ------------------------------------------------------------
   // AHB-Lite slave
   // ------------------------------------------------------------
   assign bus_go = hsel & hready & htrans[1];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= ptm_pkg::PTM_RESET_BYTE;
      end else if (hready) begin
         wr_pend_q <= bus_go & hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // register writes; single pulse clears on bit after match A
   // function field is software's to keep stable
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl0_q <= ptm_pkg::PTM_RESET_BYTE;
         mode_q  <= ptm_pkg::PTM_RESET_BYTE;
         cmpa_q  <= ptm_pkg::PTM_CNT_ZERO;
         per_q   <= ptm_pkg::PTM_CNT_ZERO;
      end else begin
         if (wr_pend_q) begin
            if (wr_addr_q == ptm_pkg::PTM_OFF_CTRL0) begin
               ctrl0_q <= hwdata[7:0] & ptm_pkg::PTM_CTRL0_MASK;
            end else if (wr_addr_q == ptm_pkg::PTM_OFF_MODE) begin
               mode_q <= hwdata[7:0];
            end else if (wr_addr_q == ptm_pkg::PTM_OFF_CMPA_LO) begin
               cmpa_q[7:0] <= hwdata[7:0];
            end else if (wr_addr_q == ptm_pkg::PTM_OFF_CMPA_HI) begin
               cmpa_q[9:8] <= hwdata[1:0];
            end else if (wr_addr_q == ptm_pkg::PTM_OFF_PER_LO) begin
               per_q[7:0] <= hwdata[7:0];
            end else if (wr_addr_q == ptm_pkg::PTM_OFF_PER_HI) begin
               per_q[9:8] <= hwdata[1:0];
            end
         end
         if (sp_stop) begin
            ctrl0_q[PTM_ON] <= 1'b0;
         end
      end
   end

   // sticky status of events; write one to clear, set wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_q <= ptm_pkg::PTM_PRE_ZERO;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (wr_pend_q && wr_addr_q == ptm_pkg::PTM_OFF_STATUS &&
                hwdata[i]) begin
               status_q[i] <= 1'b0;
            end
         end
         if (tick & match_a) status_q[0] <= 1'b1;
         if (tick & match_p & ~p_quiet) status_q[1] <= 1'b1;
         if (cap_hit) status_q[2] <= 1'b1;
      end
   end

   // read data, registered in the address phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_go & ~hwrite) begin
         if (haddr[7:0] == ptm_pkg::PTM_OFF_CTRL0) begin
            hrdata <= {24'h000000, ctrl0_q};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_MODE) begin
            hrdata <= {24'h000000, mode_q};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_CNT_LO) begin
            hrdata <= {24'h000000, cnt_q[7:0]};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_CNT_HI) begin
            hrdata <= {24'h000000, hi_bits(cnt_q)};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_CMPA_LO) begin
            hrdata <= {24'h000000, cmpa_q[7:0]};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_CMPA_HI) begin
            hrdata <= {24'h000000, hi_bits(cmpa_q)};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_PER_LO) begin
            hrdata <= {24'h000000, per_q[7:0]};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_PER_HI) begin
            hrdata <= {24'h000000, hi_bits(per_q)};
         end else if (haddr[7:0] == ptm_pkg::PTM_OFF_STATUS) begin
            hrdata <= {29'h00000000, status_q};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // zero wait states, always OKAY
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule : ptm_timer

// ---- rtl/ptm_pkg.sv ----
// Purpose: constants for the periodic timer control and counter registers
// Assumes: AHB-Lite word registers, 8-bit data in the low byte
// Notes:   offsets are byte addresses, one aligned word each
package ptm_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] PTM_OFF_CTRL0   = 8'h00;
   localparam logic [7:0] PTM_OFF_MODE    = 8'h04;
   localparam logic [7:0] PTM_OFF_CNT_LO  = 8'h08;
   localparam logic [7:0] PTM_OFF_CNT_HI  = 8'h0c;
   localparam logic [7:0] PTM_OFF_CMPA_LO = 8'h10;
   localparam logic [7:0] PTM_OFF_CMPA_HI = 8'h14;
   localparam logic [7:0] PTM_OFF_PER_LO  = 8'h18;
   localparam logic [7:0] PTM_OFF_PER_HI  = 8'h1c;
   localparam logic [7:0] PTM_OFF_STATUS  = 8'h20;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PTM_CTRL0_ON    = 3;
   localparam int PTM_CTRL0_CKLO  = 4;
   localparam int PTM_CTRL0_CKHI  = 6;
   localparam int PTM_CTRL0_PAU   = 7;
   localparam int PTM_MODE_CCLR   = 0;
   localparam int PTM_MODE_CAPTS  = 1;
   localparam int PTM_MODE_POL    = 2;
   localparam int PTM_MODE_OC     = 3;
   localparam int PTM_MODE_IOLO   = 4;
   localparam int PTM_MODE_IOHI   = 5;
   localparam int PTM_MODE_MLO    = 6;
   localparam int PTM_MODE_MHI    = 7;

   localparam int PTM_CW = 10;
   localparam logic [7:0] PTM_CTRL0_MASK = 8'hf8;
   localparam logic [7:0] PTM_RESET_BYTE = 8'h00;
   localparam logic [9:0] PTM_CNT_ZERO   = 10'h000;
   localparam logic [9:0] PTM_CNT_ONE    = 10'h001;
   localparam logic [9:0] PTM_CNT_MAX    = 10'h3ff;
   localparam logic [2:0] PTM_PRE_ZERO   = 3'h0;
   localparam logic [2:0] PTM_PRE_ONE    = 3'h1;
   localparam logic [2:0] PTM_CK_EXT_R   = 3'h6;
   localparam logic [2:0] PTM_CK_EXT_F   = 3'h7;
   localparam logic [1:0] PTM_HTRANS_NSEQ = 2'h2;
   localparam logic [1:0] PTM_HTRANS_SEQ  = 2'h3;

   // mode field codes
   typedef enum logic [1:0] {
      PTM_M_CMP = 2'b00,
      PTM_M_CAP = 2'b01,
      PTM_M_PWM = 2'b10,
      PTM_M_TMR = 2'b11
   } ptm_mode_t;

   // output function codes
   localparam logic [1:0] PTM_IO_00 = 2'b00;
   localparam logic [1:0] PTM_IO_01 = 2'b01;
   localparam logic [1:0] PTM_IO_10 = 2'b10;
   localparam logic [1:0] PTM_IO_11 = 2'b11;

endpackage : ptm_pkg

// ---- rtl/ptm_edge.sv ----
// Purpose: registered edge detector for a synchronous pin input
// Assumes: pin already synchronous to clk
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/1ps
module ptm_edge (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic din,
   output logic      rise,
   output logic      fall
);
   logic prev_q;

   // previous sample of the pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= din;
      end
   end

   assign rise = din & ~prev_q;
   assign fall = ~din & prev_q;
endmodule : ptm_edge

// ---- tb/ptm_timer_sva.sv ----
// Purpose: port checker for the periodic timer
// Assumes: register writes land at the end of the data phase
// Notes:   mode and on bits are shadowed from bus writes
`timescale 1ns/1ps
module ptm_timer_sva (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        timer_pin_a,
   input wire logic        timer_pin_b,
   input wire logic        match_a_evt,
   input wire logic        match_p_evt,
   input wire logic        capture_evt
);
   logic       wr_q;
   logic [7:0] wa_q;
   logic [7:0] md_q;
   logic       on_q;
   logic [1:0] st_q;
   wire        take = hsel & hready & htrans[1];
   wire  [1:0] m    = md_q[7:6];
   wire  [1:0] io   = md_q[5:4];
   wire        rdy  = (st_q == 2'h3);

   // shadow of mode and on bits; st_q counts edges since a write, stopping at 3
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         md_q <= 8'h00;
         on_q <= 1'b0;
         st_q <= 2'h0;
      end else begin
         wr_q <= take & hwrite;
         wa_q <= haddr[7:0];
         if (wr_q && wa_q == ptm_pkg::PTM_OFF_MODE)
            md_q <= hwdata[7:0];
         if (wr_q && wa_q == ptm_pkg::PTM_OFF_CTRL0)
            on_q <= hwdata[3];
         st_q <= wr_q ? 2'h0 : (rdy ? st_q : st_q + 2'h1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   pins_same_a: assert property (timer_pin_a == timer_pin_b)
      else $error("output pins differ");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   hi_read_a: assert property (take && !hwrite &&
      haddr[7:0] inside {8'h0c, 8'h14, 8'h1c} |=> hrdata[31:2] == 30'h0)
      else $error("high register upper bits not zero");
   unmapped_a: assert property (take && !hwrite && haddr[7:0] > 8'h20
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
   cap_off_a: assert property (rdy && m == 2'h1 && io == 2'h3
      |-> !capture_evt) else $error("capture while disabled");
   tmr_pin_a: assert property (rdy && m == 2'h3 |-> !timer_pin_a)
      else $error("pin active in timer mode");
   pwm_force_a: assert property (rdy && on_q && m == 2'h2 && !io[1]
      |-> timer_pin_a == ((md_q[3] ~^ io[0]) ^ md_q[2]))
      else $error("forced pwm level wrong");
   on_restore_a: assert property ($rose(on_q) && m == 2'h0
      |-> ##[1:3] timer_pin_a == (md_q[3] ^ md_q[2]))
      else $error("initial level not restored");
   cmp_level_a: assert property (match_a_evt && m == 2'h0 &&
      io inside {2'h1, 2'h2} |-> ##[0:2] timer_pin_a == (io[1] ^ md_q[2]))
      else $error("compare level wrong");

   match_a_c: cover property (match_a_evt);
   match_p_c: cover property (match_p_evt);
   capture_c: cover property (capture_evt);
endmodule : ptm_timer_sva

bind ptm_timer ptm_timer_sva u_sva (.clk, .resetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .timer_pin_a, .timer_pin_b, .match_a_evt, .match_p_evt, .capture_evt);

// ---- tb/ptm_pin_model.sv ----
// Purpose: far side pins: capture input and external clock
// Assumes: pins are synchronous to clk
// Notes:   levels follow the bench commands one clock later
`timescale 1ns/1ps
module ptm_pin_model (
   input wire logic clk,
   input wire logic cap_cmd,
   input wire logic ext_cmd,
   output logic     capture_pin = 1'b0,
   output logic     ext_clock_pin = 1'b0
);
   // registered so edges never coincide with the bench strobe
   always @(posedge clk) begin
      capture_pin   <= cap_cmd;
      ext_clock_pin <= ext_cmd;
   end
endmodule : ptm_pin_model

// ---- tb/periodic_timer_ctrl_and_counter_regs_tb_top.sv ----
// Purpose: self-checking bench for the periodic timer
// Assumes: zero wait state slave, waits stay bounded
// Notes:   counts ticked by hand through tick_int
`timescale 1ns/1ps
module periodic_timer_ctrl_and_counter_regs_tb_top;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic        tick_int = 1'b0;
   logic        cap_cmd = 1'b0;
   logic        ext_cmd = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout, pin_a, pin_b, ma, mp, ce, cap_pin, ext_pin;
   int          miscompares = 0;
   int          compares = 0;
   int          na = 0;
   int          np = 0;
   int          nc = 0;
   int          nr = 0;

   ptm_timer DUT (.clk(clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .capture_pin(cap_pin), .ext_clock_pin(ext_pin),
      .tick_int(tick_int), .timer_pin_a(pin_a), .timer_pin_b(pin_b),
      .match_a_evt(ma), .match_p_evt(mp), .capture_evt(ce));
   ptm_pin_model u_pins (.clk(clk), .cap_cmd(cap_cmd), .ext_cmd(ext_cmd),
      .capture_pin(cap_pin), .ext_clock_pin(ext_pin));

   initial begin
      forever #4 clk = ~clk;
   end

   // event counters; pulses last one cycle
   always @(posedge clk) begin
      na <= na + int'(ma === 1'b1);
      np <= np + int'(mp === 1'b1);
      nc <= nc + int'(ce === 1'b1);
      nr <= nr + int'($rose(pin_a));
   end

   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp);
      compares++;
      if (got != exp) begin
         miscompares++;
         $display("mismatch at %0t: count %0d want %0d", $time, got, exp);
      end
   endtask : chk_n

   // hready is sampled at each edge; a stuck bus ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         stop_test();
      end
   endtask : wait_rdy

   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [7:0] d, output logic [31:0] q);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= ptm_pkg::PTM_HTRANS_NSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
      q = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 8'h00, q);
      chk(q, e);
   endtask : rc

   task automatic ticks(input int n);
      repeat (n) begin
         tick_int <= 1'b1;
         @(posedge clk);
         tick_int <= 1'b0;
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask : ticks

   // off then on: restarts the counter from zero
   task automatic restart(input logic [7:0] mode);
      wr(ptm_pkg::PTM_OFF_CTRL0, 8'h00); // switch off first
      wr(ptm_pkg::PTM_OFF_MODE, mode);
      wr(ptm_pkg::PTM_OFF_CTRL0, 8'h08);
      repeat (4) @(posedge clk);
   endtask : restart

   task automatic s_regs;
      for (int i = 0; i < 8; i++)
         rc(8'(i * 4), 32'h0); // reset values
      wr(ptm_pkg::PTM_OFF_CMPA_LO, 8'ha5);
      wr(ptm_pkg::PTM_OFF_CMPA_HI, 8'hff);
      wr(ptm_pkg::PTM_OFF_PER_LO, 8'h5a);
      wr(ptm_pkg::PTM_OFF_PER_HI, 8'hfe);
      wr(ptm_pkg::PTM_OFF_CNT_LO, 8'h77);
      wr(ptm_pkg::PTM_OFF_CNT_HI, 8'hff);
      rc(ptm_pkg::PTM_OFF_CMPA_LO, 32'ha5); // read back
      rc(ptm_pkg::PTM_OFF_CMPA_HI, 32'h03); // upper bits
      rc(ptm_pkg::PTM_OFF_PER_LO, 32'h5a); // read back
      rc(ptm_pkg::PTM_OFF_PER_HI, 32'h02); // upper bits
      rc(ptm_pkg::PTM_OFF_CNT_LO, 32'h0); // read only
      rc(ptm_pkg::PTM_OFF_CNT_HI, 32'h0); // read only
      rc(8'h40, 32'h0);
   endtask : s_regs

   task automatic s_count;
      logic [31:0] q;
      int          n0;
      wr(ptm_pkg::PTM_OFF_PER_LO, 8'h00);
      wr(ptm_pkg::PTM_OFF_PER_HI, 8'h00);
      restart(8'hfc);
      chk({31'h0, pin_a}, 32'h0); // no pin in timer mode
      ticks(20);
      rc(ptm_pkg::PTM_OFF_CNT_LO, 32'd20); // overflow only
      wr(ptm_pkg::PTM_OFF_CTRL0, 8'h00);
      ticks(3);
      rc(ptm_pkg::PTM_OFF_CNT_LO, 32'd20); // residual kept
      wr(ptm_pkg::PTM_OFF_CTRL0, 8'h08);
      @(posedge clk);
      rc(ptm_pkg::PTM_OFF_CNT_LO, 32'd0); // zero on restart
      wr(ptm_pkg::PTM_OFF_CMPA_LO, 8'h05);
      wr(ptm_pkg::PTM_OFF_CMPA_HI, 8'h00);
      restart(8'hc1);
      n0 = np;
      ticks(20);
      chk_n(np - n0, 0); // no P event when A clears
      xfer(ptm_pkg::PTM_OFF_CNT_LO, 1'b0, 8'h00, q);
      chk(32'(q < 32'd6), 32'h1); // cleared by match A
      wr(ptm_pkg::PTM_OFF_PER_LO, 8'h08);
      restart(8'hc0);
      n0 = np;
      ticks(16);
      chk_n(np - n0, 1); // one P match
      xfer(ptm_pkg::PTM_OFF_CNT_LO, 1'b0, 8'h00, q);
      chk(32'(q < 32'd9 && q > 32'd5), 32'h1); // cleared by match P
      rc(ptm_pkg::PTM_OFF_STATUS, 32'h3); // match A and P seen
      wr(ptm_pkg::PTM_OFF_STATUS, 8'h07);
      rc(ptm_pkg::PTM_OFF_STATUS, 32'h0); // events cleared
      wr(ptm_pkg::PTM_OFF_PER_LO, 8'h00);
   endtask : s_count

   // cases are {function, initial level, invert}; A is 5
   task automatic s_cmp;
      logic [3:0] cs[5] = '{4'b1110, 4'b1010, 4'b0110, 4'b0000, 4'b1001};
      logic       lv;
      int         n0;
      foreach (cs[i]) begin
         lv = (cs[i][3:2] == 2'h3) ? ~cs[i][1] :
              (cs[i][3:2] == 2'h0) ? cs[i][1] : cs[i][3];
         restart({2'h0, cs[i], 2'h1});
         chk({31'h0, pin_a}, {31'h0, cs[i][1] ^ cs[i][0]});
         n0 = na;
         ticks(5);
         chk_n(na - n0, 0); // no early match
         ticks(1);
         chk_n(na - n0, 1); // match at A
         chk({31'h0, pin_a}, {31'h0, lv ^ cs[i][0]});
         chk({31'h0, pin_b}, {31'h0, lv ^ cs[i][0]}); // same signal
      end
   endtask : s_cmp

   // both pins pulse each case; only the selected source counts
   task automatic s_cap;
      logic [2:0] sel[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
      int         ex[6] = '{1, 1, 2, 0, 1, 2};
      int         n0;
      foreach (sel[i]) begin
         restart({2'h1, sel[i][1:0], 2'h0, sel[i][2], 1'b0});
         n0 = nc;
         cap_cmd <= 1'b1;
         repeat (4) @(posedge clk);
         cap_cmd <= 1'b0;
         repeat (4) @(posedge clk);
         ext_cmd <= 1'b1;
         repeat (4) @(posedge clk);
         ext_cmd <= 1'b0;
         repeat (4) @(posedge clk);
         chk_n(nc - n0, ex[i]); // edge and source
      end
   endtask : s_cap

   task automatic s_pwm;
      int n0;
      for (int i = 0; i < 8; i++) begin
         restart({2'h2, 1'b0, 3'(i), 2'h0});
         chk({31'h0, pin_a}, 32'((i[2] ? i[1] : !i[1]) ^ i[0]));
      end
      wr(ptm_pkg::PTM_OFF_CMPA_LO, 8'h02);
      wr(ptm_pkg::PTM_OFF_PER_LO, 8'h04);
      restart(8'ha9);
      n0 = nr;
      ticks(16);
      chk_n(nr - n0, 3); // period set by P
      restart(8'hb8);
      chk({31'h0, pin_a}, 32'h1); // pulse active
      ticks(4);
      chk({31'h0, pin_a}, 32'h0); // pulse ends at match A
      rc(ptm_pkg::PTM_OFF_CTRL0, 32'h0); // on bit cleared
   endtask : s_pwm

   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      stop_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      s_regs();
      s_count();
      s_cmp();
      s_cap();
      s_pwm();
      stop_test();
   end
endmodule : periodic_timer_ctrl_and_counter_regs_tb_top
